/* File: core/srw_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor
  import srw_pkg::*;
#(
  parameter int unsigned RESET_LIMIT = RESET_CYCLES,
  parameter int unsigned WDOG_LIMIT = WDOG_CYCLES,
  parameter int unsigned GATE_LIMIT = GATE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic main_below_reset,
  input wire logic main_below_backup,
  input wire logic main_above_4v,
  input wire logic backup_above_good,
  input wire logic manual_reset_n,
  input wire logic manual_reset_open,
  input wire logic watchdog_kick,
  input wire logic watchdog_kick_open,
  input wire logic chip_sel_in_n,
  output logic sys_reset_n,
  output logic sys_reset,
  output logic watchdog_fault_n,
  output logic chip_sel_out_n,
  output logic backup_source_active,
  output logic backup_level_good
);
  initial begin
    if (RESET_LIMIT < 2 || GATE_LIMIT < 1 || GATE_LIMIT >= RESET_LIMIT)
      $error("Bad timing parameters");
  end
  // True once a cycle counter has reached the last cycle of its span
  function automatic logic at_limit(input logic [CNT_W-1:0] cnt, input int unsigned limit);
    return cnt >= CNT_W'(limit - 1);
  endfunction
  // Two-flop synchronisers for the eight supply, manual-reset and watchdog pin inputs
  // They idle at no trigger, so no false battery selection follows reset
  localparam int unsigned NSYNC = 8;
  logic [NSYNC-1:0] meta_q, sync_q, pins;
  assign pins = {main_below_reset, main_below_backup, main_above_4v, backup_above_good,
                 manual_reset_n, manual_reset_open, watchdog_kick, watchdog_kick_open};
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= SYNC_IDLE;
      sync_q <= SYNC_IDLE;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end
  logic s_below, s_below_bat, s_4v, s_bgood, s_mr_n, s_mr_open, s_kick, s_kick_open;
  assign {s_below, s_below_bat, s_4v, s_bgood, s_mr_n, s_mr_open, s_kick, s_kick_open} =
    sync_q;
  logic mr_active;
  assign mr_active = !s_mr_n && !s_mr_open;
  logic trigger;
  assign trigger = s_below || mr_active;
  srw_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] gate_cnt_q, gate_cnt_d;
  logic gate_en_q, gate_en_d;
  logic bat_q, bat_d;
  logic bok_q, bok_d;
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      SRW_RUN: begin
        if (trigger) begin
          state_d = SRW_HOLD;
          cnt_d = '0;
        end
      end
      // HOLD keeps the count at zero, so each bounce restarts the full timeout
      SRW_HOLD: begin
        cnt_d = '0;
        if (!trigger) state_d = SRW_TIMEOUT;
      end
      SRW_TIMEOUT: begin
        if (trigger) begin
          state_d = SRW_HOLD;
          cnt_d = '0;
        end else if (at_limit(cnt_q, RESET_LIMIT)) begin
          state_d = SRW_RUN;
          cnt_d = '0;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = SRW_HOLD;
        cnt_d = '0;
      end
    endcase
  end
  logic reset_active;
  assign reset_active = (state_q != SRW_RUN);
  // Gate: off from rst_n, else GATE_LIMIT cycles after reset asserts; back on the cycle after release
  always_comb begin
    gate_en_d = gate_en_q;
    gate_cnt_d = gate_cnt_q;
    if (!reset_active) begin
      gate_en_d = 1'b1;
      gate_cnt_d = '0;
    end else if (gate_en_q) begin
      if (at_limit(gate_cnt_q, GATE_LIMIT)) begin
        gate_en_d = 1'b0;
      end else begin
        gate_cnt_d = gate_cnt_q + 1'b1;
      end
    end
  end
  always_comb begin
    bat_d = s_below && s_below_bat;
    bok_d = s_4v && s_bgood;
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= SRW_HOLD;
      cnt_q <= '0;
      gate_cnt_q <= '0;
      gate_en_q <= 1'b0;
      bat_q <= 1'b0;
      bok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      gate_cnt_q <= gate_cnt_d;
      gate_en_q <= gate_en_d;
      bat_q <= bat_d;
      bok_q <= bok_d;
    end
  end
  srw_watchdog #(
    .WDOG_LIMIT(WDOG_LIMIT)
  ) u_wdog (
    .mclk(mclk),
    .rst_n(rst_n),
    .reset_active(reset_active),
    .kick_sync(s_kick),
    .kick_open(s_kick_open),
    .fault_n(watchdog_fault_n)
  );
  assign sys_reset_n = !reset_active;
  assign sys_reset = reset_active;
  assign chip_sel_out_n = gate_en_q ? chip_sel_in_n : 1'b1;
  assign backup_source_active = bat_q;
  assign backup_level_good = bok_q;
  // Checks on the reset sequence
  AST_RESET_COMPLEMENT: assert property (@(posedge mclk) disable iff (!rst_n)
    sys_reset == !sys_reset_n)
    else $error("reset outputs not complementary");
  AST_TRIGGER_ASSERTS: assert property (@(posedge mclk) disable iff (!rst_n)
    trigger |=> !sys_reset_n)
    else $error("trigger did not assert reset");
  AST_UV_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n)
    s_below |=> (state_q == SRW_HOLD))
    else $error("undervoltage did not hold reset");
  AST_MR_HOLDS: assert property (@(posedge mclk) disable iff (!rst_n)
    mr_active |=> (state_q == SRW_HOLD))
    else $error("manual reset did not hold reset");
  AST_MR_OPEN_IGNORED: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_mr_open && !s_below && state_q == SRW_RUN) |=> sys_reset_n)
    else $error("open manual reset input caused a reset");
  AST_TIMEOUT_ENTRY: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == SRW_HOLD && !trigger)
    |=> (state_q == SRW_TIMEOUT && cnt_q == '0))
    else $error("timeout did not start from zero");
  AST_HOLD_CLEARS: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == SRW_HOLD) |=> (cnt_q == '0))
    else $error("count not cleared while held");
  AST_MIN_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    (reset_active && !(state_q == SRW_TIMEOUT && at_limit(cnt_q, RESET_LIMIT)))
    |=> !sys_reset_n)
    else $error("timeout too short");
  AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == SRW_TIMEOUT && !trigger && !at_limit(cnt_q, RESET_LIMIT))
    |=> (state_q == SRW_TIMEOUT && cnt_q == $past(cnt_q) + 1'b1))
    else $error("timeout count did not advance");
  AST_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == SRW_TIMEOUT && !trigger && at_limit(cnt_q, RESET_LIMIT)) |=> sys_reset_n)
    else $error("reset not released after timeout");
  AST_RESTART: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_q == SRW_TIMEOUT && trigger) |=> (state_q == SRW_HOLD && cnt_q == '0))
    else $error("timeout not restarted");
  // Checks on the chip-select gate
  AST_GATE_FORCE: assert property (@(posedge mclk) disable iff (!rst_n)
    !gate_en_q |-> chip_sel_out_n)
    else $error("gated select not high");
  AST_GATE_DELAY: assert property (@(posedge mclk) disable iff (!rst_n)
    (reset_active && gate_en_q && !at_limit(gate_cnt_q, GATE_LIMIT)) |=> gate_en_q)
    else $error("gate disabled too early");
  AST_GATE_OFF_IN_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
    (reset_active && gate_en_q && at_limit(gate_cnt_q, GATE_LIMIT)) |=> !gate_en_q)
    else $error("gate not disabled");
  AST_GATE_STAYS_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    (reset_active && !gate_en_q) |=> !gate_en_q)
    else $error("gate opened during reset");
  AST_GATE_ON_RUN: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(sys_reset_n) |=> gate_en_q)
    else $error("gate not re-enabled");
  AST_GATE_RUN_ON: assert property (@(posedge mclk) disable iff (!rst_n)
    !reset_active |=> (gate_en_q && gate_cnt_q == '0))
    else $error("gate not open while running");
  // Checks on supply selection and the battery flag
  AST_BACKUP_SUPPLY_SEL: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_below && s_below_bat) |=> backup_source_active)
    else $error("battery not selected");
  AST_MAIN_SEL: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_below |=> !backup_source_active)
    else $error("main not selected");
  AST_BACKUP_SUPPLY_MAIN: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_below_bat |=> !backup_source_active)
    else $error("battery selected above battery level");
  AST_BOK: assert property (@(posedge mclk) disable iff (!rst_n)
    (s_4v && s_bgood) |=> backup_level_good)
    else $error("battery good flag low");
  AST_BOK_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    !(s_4v && s_bgood) |=> !backup_level_good)
    else $error("battery good flag high");
endmodule
`default_nettype wire

/* File: core/srw_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
module srw_watchdog
  import srw_pkg::*;
#(
  parameter int unsigned WDOG_LIMIT = WDOG_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reset_active,
  input wire logic kick_sync,
  input wire logic kick_open,
  output logic fault_n
);
  initial begin
    if (WDOG_LIMIT < 2) $error("WDOG_LIMIT too small");
  end
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic kick_prev_q, kick_prev_d;
  logic fault_q, fault_d;
  logic kick_edge;
  assign kick_edge = kick_sync ^ kick_prev_q;
  always_comb begin
    kick_prev_d = kick_sync;
    cnt_d = cnt_q;
    fault_d = fault_q;
    if (reset_active || kick_open) begin
      cnt_d = '0;
      fault_d = 1'b0;
    end else if (kick_edge) begin
      cnt_d = '0;
      fault_d = 1'b0;
    end else if (cnt_q >= CNT_W'(WDOG_LIMIT - 1)) begin
      fault_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      kick_prev_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      kick_prev_q <= kick_prev_d;
      fault_q <= fault_d;
    end
  end
  assign fault_n = ~fault_q;
  AST_WDOG_HIGH_IN_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
    reset_active |=> fault_n)
    else $error("fault during reset");
  AST_WDOG_OPEN: assert property (@(posedge mclk) disable iff (!rst_n)
    kick_open |=> fault_n)
    else $error("fault while kick open");
  AST_WDOG_FAULT: assert property (@(posedge mclk) disable iff (!rst_n)
    (!reset_active && !kick_open && !kick_edge && cnt_q >= CNT_W'(WDOG_LIMIT - 1))
    |=> !fault_n)
    else $error("stalled kick not flagged");
  AST_WDOG_KICK_CLEARS: assert property (@(posedge mclk) disable iff (!rst_n)
    (!reset_active && !kick_open && kick_edge) |=> fault_n)
    else $error("kick edge did not clear fault");
  AST_WDOG_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    (reset_active || kick_edge) |=> (cnt_q == '0))
    else $error("watchdog count not cleared");
endmodule
`default_nettype wire

/* File: include/srw_pkg.sv */
package srw_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned RESET_TIMEOUT_MS = 200;
  localparam int unsigned WDOG_TIMEOUT_MS = 1600;
  localparam int unsigned GATE_DELAY_US = 28;
  localparam int unsigned RESET_CYCLES = RESET_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned WDOG_CYCLES = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned GATE_CYCLES = GATE_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W = 32;
  // Synchroniser idle value: no supply trigger, manual reset inactive, kick input open
  localparam logic [7:0] SYNC_IDLE = 8'h09;
  typedef enum logic [1:0] {
    SRW_RUN = 2'b00,
    SRW_HOLD = 2'b01,
    SRW_TIMEOUT = 2'b11
  } srw_state_t;
endpackage

/* File: tb/srw_host.sv */
`timescale 1ns/1ps
`default_nettype none
module srw_host (
  input wire logic mclk,
  input wire logic kick_en,
  output logic watchdog_kick,
  output logic chip_sel_in_n
);
  logic [2:0] div_q = 3'h0;
  logic kick_q = 1'b0;
  logic sel_q = 1'b1;
  // Processor toggles the RAM select every cycle and kicks every eighth cycle while alive
  always @(posedge mclk) begin
    div_q <= div_q + 3'h1;
    sel_q <= ~sel_q;
    if (kick_en && div_q == 3'h7) begin
      kick_q <= ~kick_q;
    end
  end
  assign watchdog_kick = kick_q;
  assign chip_sel_in_n = sel_q;
endmodule
`default_nettype wire

/* File: tb/tb_srw_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_srw_supervisor;
  localparam int RL = 20;
  localparam int WL = 50;
  logic mclk, rst_n, mbr, mbb, m4v, bag, manual_reset_n, mr_open, kick, kick_open, cs_in_n;
  logic sys_reset_n, sys_reset, fault_n, cs_out_n, bsa, blg, kick_en;
  int n_errors = 0;
  int checks = 0;
  int n;
  srw_supervisor #(.RESET_LIMIT(RL), .WDOG_LIMIT(WL), .GATE_LIMIT(4)) i_dut (.mclk(mclk),
    .rst_n(rst_n), .main_below_reset(mbr), .main_below_backup(mbb), .main_above_4v(m4v),
    .backup_above_good(bag), .manual_reset_n(manual_reset_n), .manual_reset_open(mr_open),
    .watchdog_kick(kick), .watchdog_kick_open(kick_open), .chip_sel_in_n(cs_in_n),
    .sys_reset_n(sys_reset_n), .sys_reset(sys_reset), .watchdog_fault_n(fault_n),
    .chip_sel_out_n(cs_out_n), .backup_source_active(bsa), .backup_level_good(blg));
  srw_host i_host (.mclk(mclk), .kick_en(kick_en), .watchdog_kick(kick),
    .chip_sel_in_n(cs_in_n));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic chk_rel(input int pre);
    n = pre;
    while (sys_reset_n !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk("hold_min", 1'b1, n >= RL);
    chk("hold_max", 1'b1, n <= RL + 6);
  endtask
  task automatic wait_fault();
    n = 0;
    while (fault_n !== 1'b0 && n < WL + 30) begin
      @(posedge mclk);
      n++;
    end
    chk("fault", 1'b0, fault_n);
  endtask
  task automatic t_por();
    cyc(8);
    chk("rst_n_out", 1'b0, sys_reset_n);
    chk("rst_out", 1'b1, sys_reset);
    chk("cs_gated", 1'b1, cs_out_n);
    chk("fault_in_rst", 1'b1, fault_n);
    chk_rel(8);
    cyc(2);
    chk("rst_out", 1'b0, sys_reset);
    chk("cs_pass", cs_in_n, cs_out_n);
    $display("por done");
  endtask
  task automatic t_manual();
    for (int i = 0; i < 4; i++) begin
      manual_reset_n <= 1'b0;
      cyc(5);
      if (i == 0) chk("cs_delay", cs_in_n, cs_out_n);
      cyc(3);
      chk("mr_rst", 1'b0, sys_reset_n);
      chk("cs_gated", 1'b1, cs_out_n);
      manual_reset_n <= 1'b1;
      if (i < 3) cyc(8);
    end
    chk_rel(0);
    mr_open <= 1'b1;
    manual_reset_n <= 1'b0;
    cyc(6);
    chk("mr_open", 1'b1, sys_reset_n);
    manual_reset_n <= 1'b1;
    mr_open <= 1'b0;
    cyc(4);
    $display("manual done");
  endtask
  task automatic t_brown();
    mbr <= 1'b1;
    mbb <= 1'b1;
    cyc(6);
    chk("uv_rst", 1'b0, sys_reset_n);
    chk("on_backup_supply", 1'b1, bsa);
    mbb <= 1'b0;
    cyc(5);
    chk("on_main", 1'b0, bsa);
    mbr <= 1'b0;
    cyc(10);
    mbr <= 1'b1;
    cyc(2);
    mbr <= 1'b0;
    chk_rel(0);
    mbb <= 1'b1;
    cyc(6);
    chk("on_main", 1'b0, bsa);
    mbb <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      {m4v, bag} <= i[1:0];
      cyc(5);
      chk("backup_level_good", i == 3, blg);
    end
    $display("supply done");
  endtask
  task automatic t_wdog();
    cyc(WL + 20);
    chk("fault", 1'b1, fault_n);
    kick_en <= 1'b0;
    wait_fault();
    chk("wd_time", 1'b1, n >= WL - 10);
    kick_en <= 1'b1;
    cyc(14);
    chk("fault_clr", 1'b1, fault_n);
    kick_en <= 1'b0;
    wait_fault();
    manual_reset_n <= 1'b0;
    cyc(5);
    chk("fault_rst", 1'b1, fault_n);
    manual_reset_n <= 1'b1;
    chk_rel(0);
    kick_open <= 1'b1;
    cyc(WL + 30);
    chk("fault_open", 1'b1, fault_n);
    $display("watchdog done");
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {rst_n, mbr, mbb, m4v, bag, mr_open, kick_open} = 7'h00;
    manual_reset_n = 1'b1;
    kick_en = 1'b1;
    cyc(5);
    rst_n <= 1'b1;
    t_por();
    t_manual();
    t_brown();
    t_wdog();
    summarize();
  end
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
